// >>> inc/dcs_pkg.sv
package dcs_pkg;

    // Control word bit positions
    localparam int CW_ENERGIZE   = 0;
    localparam int CW_NO_STOP    = 1;
    localparam int CW_JOG_PLUS   = 2;
    localparam int CW_JOG_MINUS  = 3;
    localparam int CW_OUT_LSB    = 4;
    localparam int CW_OUT_MSB    = 7;
    localparam int CW_ADDR_LSB   = 8;
    localparam int CW_ADDR_MSB   = 12;
    localparam int CW_START      = 13;
    localparam int CW_NO_STOP_2  = 14;
    localparam int CW_BRAKE_OPEN = 15;

    // Primary status word field positions
    localparam int SW1_PINS_LSB  = 0;
    localparam int SW1_PINS_MSB  = 7;
    localparam int SW1_NO_ERROR  = 8;
    localparam int SW1_POS_REACH = 9;
    localparam int SW1_POWERLESS = 10;
    localparam int SW1_ENER_ZERO = 11;
    localparam int SW1_HOME_KNOWN = 12;
    localparam int SW1_PSB_LSB   = 13;
    localparam int SW1_PSB_MSB   = 15;

    // Secondary status word field positions
    localparam int SW2_REG_DET   = 15;

    // Reset values
    localparam logic [15:0] CW_RESET  = 16'h0000;
    localparam logic [15:0] SW_RESET  = 16'h0000;
    localparam logic [4:0]  ADDR_RESET = 5'h00;
    localparam logic [2:0]  PSB_RESET = 3'h0;

    // Motion set address space: set 0 is the homing run
    localparam int          SET_COUNT = 32;
    localparam logic [4:0]  HOMING_SET = 5'h00;

    // Action that a motion set applies to one programmable flag
    typedef enum logic [1:0] {
        DCS_PSB_KEEP,
        DCS_PSB_CLEAR,
        DCS_PSB_SET
    } dcs_psb_act_t;

    typedef struct packed {
        dcs_psb_act_t flag_two;
        dcs_psb_act_t flag_one;
        dcs_psb_act_t flag_zero;
    } dcs_psb_pat_t;

    // Hard-wired digital inputs
    typedef struct packed {
        logic home_sensor_pin;
        logic limit_switch_two_pin;
        logic limit_switch_one_pin;
        logic registration_pin;
        logic jog_minus_pin;
        logic jog_plus_pin;
        logic stop_release_pin;
        logic axis_energize_pin;
    } dcs_pins_t;

    // Drive state reported by the power stage and motion engine
    typedef struct packed {
        logic reg_detected;
        logic home_known;
        logic axis_energized_zero;
        logic power_stage_off;
        logic position_reached;
        logic no_error;
    } dcs_drive_state_t;

    // Commands handed to the motion engine
    typedef struct packed {
        logic       axis_enable;
        logic       stop_active;
        logic       jog_plus;
        logic       jog_minus;
        logic       brake_open;
        logic       error_ack;
        logic       set_start;
        logic       homing_start;
        logic [4:0] set_addr;
    } dcs_cmd_t;

endpackage

// >>> tb/dcs_host_model.sv
`timescale 1ns/1ps
// Host controller delivering control words over the serial link
module dcs_host_model (
    // Clock
    input  wire logic   sys_clk,
    // Control word write
    output logic        cw_wr,
    output logic [15:0] cw_wdata
);
    logic [15:0] last_word;

    // Idle: no strobe, data inverted so a stale word never looks live
    initial begin
        cw_wr     = 1'b0;
        cw_wdata  = 16'hffff;
        last_word = 16'h0000;
    end

    // One word after gap idle cycles; a start bit still high is dropped first when w sets it too
    task automatic send(input logic [15:0] w, input int gap);
        repeat (gap) @(posedge sys_clk);
        if (w[13] && last_word[13]) begin
            put(last_word & 16'hdfff);
        end
        put(w);
    endtask

    // Strobe held for exactly one edge
    task automatic put(input logic [15:0] w);
        @(posedge sys_clk);
        cw_wr    <= 1'b1;
        cw_wdata <= w;
        @(posedge sys_clk);
        cw_wr     <= 1'b0;
        cw_wdata  <= ~w;
        last_word = w;
    endtask
endmodule

// >>> tb/dcs_words_props.sv
`timescale 1ns/1ps
// Port-level checks of the control and status word logic
module dcs_words_props (
    // Clock and reset
    input wire logic                      sys_clk,
    input wire logic                      rst_n,
    // Inputs
    input wire logic                      fixed_assign,
    input wire dcs_pkg::dcs_pins_t        pins,
    input wire dcs_pkg::dcs_drive_state_t drive,
    // Outputs
    input wire logic [15:0]               host_control_word,
    input wire logic [15:0]               primary_status_word,
    input wire logic [15:0]               secondary_status_word,
    input wire dcs_pkg::dcs_cmd_t         cmd,
    input wire logic                      set_busy,
    input wire logic                      no_error_output,
    input wire logic                      position_reached_output,
    input wire logic                      power_stage_off_output,
    input wire logic                      axis_energized_zero_output
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // The first edge after release still compares against reset-time samples, so skip it
    sequence s_start_edge;
        $past(rst_n) && $rose(host_control_word[13]);
    endsequence
    sequence s_set_pulse;
        cmd.set_start && !cmd.homing_start;
    endsequence

    a_pin_mirror: assert property ($past(rst_n) |-> primary_status_word[7:0] == $past(pins))
        else $error("status pins wrong");
    a_drive_mirror: assert property ($past(rst_n) |-> primary_status_word[12:8] ==
        {$past(drive.home_known), $past(drive[3:0])}) else $error("status drive bits wrong");
    a_reg_flag: assert property ($past(rst_n) |->
        secondary_status_word == {$past(drive.reg_detected), 15'h0000}) else $error("word two wrong");
    a_energize_and: assert property ($past(rst_n) |-> cmd.axis_enable ==
        ($past(host_control_word[0]) && ($past(pins.axis_energize_pin) || !$past(fixed_assign))))
        else $error("axis enable wrong");
    a_stop_or: assert property ($past(rst_n) |-> cmd.stop_active ==
        !($past(host_control_word[1]) && $past(host_control_word[14])
          && ($past(pins.stop_release_pin) || !$past(fixed_assign)))) else $error("stop wrong");
    a_jog_or: assert property ($past(rst_n) |->
        cmd.jog_plus == ($past(host_control_word[2]) || ($past(pins.jog_plus_pin) && $past(fixed_assign)))
        && cmd.jog_minus == ($past(host_control_word[3])
        || ($past(pins.jog_minus_pin) && $past(fixed_assign)))) else $error("jog wrong");
    a_brake_follow: assert property ($past(rst_n) |-> cmd.brake_open == $past(host_control_word[15]))
        else $error("brake wrong");
    a_free_outputs: assert property ($past(rst_n) && !$past(fixed_assign) |->
        {axis_energized_zero_output, power_stage_off_output, position_reached_output, no_error_output}
        == $past(host_control_word[7:4])) else $error("free outputs wrong");
    a_fixed_outputs: assert property ($past(rst_n) && $past(fixed_assign) |->
        {axis_energized_zero_output, power_stage_off_output, position_reached_output, no_error_output}
        == $past(drive[3:0])) else $error("fixed outputs wrong");
    a_start_load: assert property (s_start_edge ##0 host_control_word[12:8] != 5'h00 |=>
        s_set_pulse ##0 cmd.set_addr == $past(host_control_word[12:8])) else $error("start wrong");
    a_home_start: assert property (s_start_edge ##0 host_control_word[12:8] == 5'h00 && !set_busy
        |=> cmd.homing_start && !cmd.set_start) else $error("homing start wrong");
    a_ack_rise: assert property ($rose(cmd.axis_enable) |-> cmd.error_ack)
        else $error("error ack missing");
endmodule

bind dcs_drive_words dcs_words_props u_props (
    .sys_clk                    (sys_clk),
    .rst_n                      (rst_n),
    .fixed_assign               (fixed_assign),
    .pins                       (pins),
    .drive                      (drive),
    .host_control_word          (host_control_word),
    .primary_status_word        (primary_status_word),
    .secondary_status_word      (secondary_status_word),
    .cmd                        (cmd),
    .set_busy                   (set_busy),
    .no_error_output            (no_error_output),
    .position_reached_output    (position_reached_output),
    .power_stage_off_output     (power_stage_off_output),
    .axis_energized_zero_output (axis_energized_zero_output)
);

// >>> tb/test_drive_control_status_words.sv
`timescale 1ns/1ps
module test_drive_control_status_words;
    logic                      sys_clk;
    logic                      rst_n;
    logic                      fixed_assign;
    dcs_pkg::dcs_pins_t        pins;
    logic                      cw_wr;
    logic [15:0]               cw_wdata;
    logic                      pat_wr;
    logic [4:0]                pat_addr;
    dcs_pkg::dcs_psb_pat_t     pat_data;
    dcs_pkg::dcs_drive_state_t drive;
    logic                      set_done;
    logic [15:0]               host_control_word;
    logic [15:0]               primary_status_word;
    logic [15:0]               secondary_status_word;
    dcs_pkg::dcs_cmd_t         cmd;
    logic                      set_busy;
    logic [3:0]                outs;
    int                        fail_count;
    int                        n_tests;

    dcs_drive_words u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .fixed_assign(fixed_assign), .pins(pins),
        .cw_wr(cw_wr), .cw_wdata(cw_wdata), .pat_wr(pat_wr), .pat_addr(pat_addr),
        .pat_data(pat_data), .drive(drive), .set_done(set_done),
        .host_control_word(host_control_word), .primary_status_word(primary_status_word),
        .secondary_status_word(secondary_status_word), .cmd(cmd), .set_busy(set_busy),
        .no_error_output(outs[0]), .position_reached_output(outs[1]),
        .power_stage_off_output(outs[2]), .axis_energized_zero_output(outs[3]));

    dcs_host_model u_host (.sys_clk(sys_clk), .cw_wr(cw_wr), .cw_wdata(cw_wdata));

    // Look one time unit after the edge so the design's updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Level inputs change on an edge; levels settle two edges later
    task automatic set_in(input logic [7:0] p, input logic [5:0] d, input logic f);
        @(posedge sys_clk);
        pins         <= p;
        drive        <= d;
        fixed_assign <= f;
        step(2);
    endtask

    task automatic done_pulse();
        @(posedge sys_clk);
        set_done <= 1'b1;
        @(posedge sys_clk);
        set_done <= 1'b0;
        step(1);
    endtask

    task automatic t_status();
        set_in(8'ha5, 6'h2a, 1'b1);
        chk(primary_status_word, 16'h0aa5);
        chk({12'h000, outs}, 16'h000a);
        chk(secondary_status_word, 16'h8000);
        set_in(8'h5a, 6'h15, 1'b1);
        chk(primary_status_word, 16'h155a);
        chk({12'h000, outs}, 16'h0005);
        chk(secondary_status_word, 16'h0000);
    endtask

    task automatic t_fixed();
        set_in(8'h00, 6'h00, 1'b1);
        u_host.send(16'h4003, 0);
        step(1);
        chk({11'h000, cmd[12:8]}, 16'h0008);
        set_in(8'h03, 6'h00, 1'b1);
        chk({11'h000, cmd[12:8]}, 16'h0010);
        set_in(8'h0a, 6'h00, 1'b1);
        chk({11'h000, cmd[12:8]}, 16'h0002);
        u_host.send(16'h0004, 3);
        step(1);
        chk({11'h000, cmd[12:8]}, 16'h000e);
    endtask

    // Free mode: pins ignored, word bits 7:4 drive the outputs
    task automatic t_free();
        set_in(8'h0f, 6'h00, 1'b0);
        u_host.send(16'hc0a3, 0);
        step(1);
        chk({11'h000, cmd[12:8]}, 16'h0011);
        chk({15'h0000, cmd.error_ack}, 16'h0001);
        chk({12'h000, outs}, 16'h000a);
        chk(host_control_word, 16'hc0a3);
    endtask

    task automatic t_sets();
        @(posedge sys_clk);
        pat_wr   <= 1'b1;
        pat_addr <= 5'h05;
        pat_data <= '{dcs_pkg::DCS_PSB_SET, dcs_pkg::DCS_PSB_KEEP, dcs_pkg::DCS_PSB_SET};
        @(posedge sys_clk);
        pat_wr <= 1'b0;
        u_host.send(16'h6003, 0);
        step(1);
        chk({13'h0000, cmd.homing_start, cmd.set_start, set_busy}, 16'h0005);
        done_pulse();
        chk({12'h000, set_busy, primary_status_word[15:13]}, 16'h0000);
        u_host.send(16'h6503, 0);
        step(1);
        chk({7'h00, set_busy, cmd[7:0]}, 16'h0145);
        u_host.send(16'h6003, 0);
        step(1);
        chk({7'h00, set_busy, cmd[7:0]}, 16'h0105);
        done_pulse();
        step(1);
        chk({13'h0000, primary_status_word[15:13]}, 16'h0005);
    endtask

    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        rst_n        = 1'b0;
        fixed_assign = 1'b1;
        pins         = '0;
        pat_wr       = 1'b0;
        pat_addr     = 5'h00;
        pat_data     = '0;
        drive        = '0;
        set_done     = 1'b0;
        fail_count   = 0;
        n_tests      = 0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_status();
        t_fixed();
        t_free();
        t_sets();
        stop_test();
    end

    // Whole run needs about 60 cycles; 1500, some 25 times that, means a hang
    initial begin
        repeat (1500) @(posedge sys_clk);
        fail_count++;
        stop_test();
    end
endmodule

// >>> verilog/dcs_drive_words.sv
`timescale 1ns/1ps
// Summary of operation
// (RULE1) Inputs 0-3 and outputs 0-3 select fixed or free assignment.
// (RULE2) Fixed: motor energized only if energize pin AND word bit 0.
// (RULE3) Fixed: stop active if release pin low OR word bit 1 clear.
// (RULE4) Jog requests from pins and word bits are ORed; code ORs them under fixed assignment only.
// (RULE5) Bit 0 acks errors on rise, energizes; bits 1-3 stop release, jogs.
// (RULE6) Word bits 4-7 drive outputs 0-3 only under free assignment.
// (RULE7) Rise of bit 13 loads set address from bits 8-12 and starts it; code ignores a rise with address zero while busy.
// (RULE8) Bit 14 is a second stop release; bit 15 opens the brake.
// (RULE9) Word bits 0-3 equal the pins only under fixed assignment.
// (RULE10) Status word 1 bits 0-7 show inputs 0-7.
// (RULE11) Bits 8-11: no error, in position, powerless, energized at zero.
// (RULE12) Bits 8-11 mirror outputs 0-3 only under fixed assignment.
// (RULE13) Status word 1 bit 12 set once home position is known.
// (RULE14) Status word 1 bits 13-15 carry programmable flags 0-2.
// (RULE15) Status word 2 bit 15 flags registration; bits 0-14 reserved.
// (RULE16) Start with address zero runs homing; sets 1-31 are normal; code ignores address zero while a set or homing runs.
// (RULE17) At set termination each flag is kept, cleared or set by pattern; code skips this for homing and when a start comes in the same cycle.
// (RULE18) Reserved status word 2 bits read zero; words refresh every cycle.
module dcs_drive_words (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // Assignment mode: 1 fixed, 0 free
    input  wire logic                     fixed_assign,
    // Hard-wired inputs
    input  wire dcs_pkg::dcs_pins_t       pins,
    // Control word write from the serial link
    input  wire logic                     cw_wr,
    input  wire logic [15:0]              cw_wdata,
    // Motion set flag pattern table write
    input  wire logic                     pat_wr,
    input  wire logic [4:0]               pat_addr,
    input  wire dcs_pkg::dcs_psb_pat_t    pat_data,
    // Drive state and set termination from the motion engine
    input  wire dcs_pkg::dcs_drive_state_t drive,
    input  wire logic                     set_done,
    // Register read-back
    output logic [15:0]                   host_control_word,
    output logic [15:0]                   primary_status_word,
    output logic [15:0]                   secondary_status_word,
    // Commands to the motion engine
    output dcs_pkg::dcs_cmd_t             cmd,
    output logic                          set_busy,
    // Digital outputs 0 to 3
    output logic                          no_error_output,
    output logic                          position_reached_output,
    output logic                          power_stage_off_output,
    output logic                          axis_energized_zero_output
);

    typedef enum logic [1:0] {
        DCS_IDLE,
        DCS_HOMING,
        DCS_RUNNING
    } dcs_state_t;

    dcs_state_t  state;
    dcs_state_t  next_state;
    logic [15:0] cw_prev;
    logic        energize_prev;
    logic        energize_req;
    logic        stop_req;
    logic        jog_plus_req;
    logic        jog_minus_req;
    logic        start_edge;
    logic        ack_edge;
    logic [4:0]  start_addr;
    logic [4:0]  run_addr;
    logic        start_ok;
    logic        psb_apply;
    logic [2:0]  psb_flags;
    logic [3:0]  fixed_outs;
    logic [3:0]  next_outs;

    // Rising edge of a level between two samples
    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction

    // Control word register, written whole by the link
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_control_word <= dcs_pkg::CW_RESET;
        end else if (cw_wr) begin
            host_control_word <= cw_wdata;
        end
    end

    // Previous sample for edge detection on word bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cw_prev <= dcs_pkg::CW_RESET;
        end else begin
            cw_prev <= host_control_word;
        end
    end

    // Merge pins and word; free assignment leaves pins 0-3 out of it
    always_comb begin
        if (fixed_assign) begin // see (RULE1) see (RULE9)
            energize_req = pins.axis_energize_pin
                         & host_control_word[dcs_pkg::CW_ENERGIZE]; // see (RULE2)
            stop_req     = ~pins.stop_release_pin
                         | ~host_control_word[dcs_pkg::CW_NO_STOP]; // see (RULE3)
            jog_plus_req  = pins.jog_plus_pin
                          | host_control_word[dcs_pkg::CW_JOG_PLUS]; // see (RULE4)
            jog_minus_req = pins.jog_minus_pin
                          | host_control_word[dcs_pkg::CW_JOG_MINUS];
        end else begin
            energize_req  = host_control_word[dcs_pkg::CW_ENERGIZE]; // see (RULE5)
            stop_req      = ~host_control_word[dcs_pkg::CW_NO_STOP];
            jog_plus_req  = host_control_word[dcs_pkg::CW_JOG_PLUS];
            jog_minus_req = host_control_word[dcs_pkg::CW_JOG_MINUS];
        end
    end

    // Energize request history for the acknowledge edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            energize_prev <= 1'b0;
        end else begin
            energize_prev <= energize_req;
        end
    end

    assign ack_edge   = rise(energize_req, energize_prev); // see (RULE5)
    assign start_edge = rise(host_control_word[dcs_pkg::CW_START],
                             cw_prev[dcs_pkg::CW_START]); // see (RULE7)
    assign start_addr = host_control_word[dcs_pkg::CW_ADDR_MSB:dcs_pkg::CW_ADDR_LSB];

    // A running set may be replaced on the fly, but never by homing,
    // since homing would discard the reference mid-move
    assign start_ok = start_edge
                    && !(state != DCS_IDLE && start_addr == dcs_pkg::HOMING_SET);

    // Motion tracking: which set the engine is executing
    always_comb begin
        next_state = state;
        case (state)
            DCS_IDLE: begin
                if (start_ok) begin
                    if (start_addr == dcs_pkg::HOMING_SET) begin // see (RULE16)
                        next_state = DCS_HOMING;
                    end else begin
                        next_state = DCS_RUNNING;
                    end
                end
            end
            DCS_HOMING: begin
                if (set_done) begin
                    next_state = DCS_IDLE;
                end
            end
            DCS_RUNNING: begin
                if (start_ok) begin
                    next_state = DCS_RUNNING;
                end else if (set_done) begin
                    next_state = DCS_IDLE;
                end
            end
            default: begin
                next_state = DCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= DCS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign set_busy = (state != DCS_IDLE);

    // Address of the set in progress; pattern lookup uses it at the end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_addr <= dcs_pkg::ADDR_RESET;
        end else if (start_ok) begin
            run_addr <= start_addr; // see (RULE7)
        end
    end

    // Termination of a normal set applies its flag pattern; homing has none,
    // and a start in the same cycle wins so the old set's pattern is skipped
    assign psb_apply = (state == DCS_RUNNING) && set_done && !start_ok;

    dcs_psb_unit u_psb (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .tbl_wr     (pat_wr),
        .tbl_addr   (pat_addr),
        .tbl_data   (pat_data),
        .apply      (psb_apply), // see (RULE17)
        .apply_addr (run_addr),
        .flags      (psb_flags)
    );

    // Registered commands; start and acknowledge are one-cycle pulses
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= '0;
        end else begin
            cmd.axis_enable  <= energize_req;
            cmd.stop_active  <= stop_req
                              | ~host_control_word[dcs_pkg::CW_NO_STOP_2]; // see (RULE8)
            cmd.jog_plus     <= jog_plus_req;
            cmd.jog_minus    <= jog_minus_req;
            cmd.brake_open   <= host_control_word[dcs_pkg::CW_BRAKE_OPEN]; // see (RULE8)
            cmd.error_ack    <= ack_edge;
            cmd.set_start    <= start_ok
                              && start_addr != dcs_pkg::HOMING_SET;
            cmd.homing_start <= start_ok
                              && start_addr == dcs_pkg::HOMING_SET; // see (RULE16)
            if (start_ok) begin
                cmd.set_addr <= start_addr;
            end
        end
    end

    // Function states that outputs 0-3 carry under fixed assignment
    assign fixed_outs = {drive.axis_energized_zero,
                         drive.power_stage_off,
                         drive.position_reached,
                         drive.no_error};

    // Free assignment hands outputs to word bits 4-7
    always_comb begin
        if (fixed_assign) begin // see (RULE1)
            next_outs = fixed_outs; // see (RULE12)
        end else begin
            next_outs = host_control_word[dcs_pkg::CW_OUT_MSB:dcs_pkg::CW_OUT_LSB]; // see (RULE6)
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            no_error_output            <= 1'b0;
            position_reached_output    <= 1'b0;
            power_stage_off_output     <= 1'b0;
            axis_energized_zero_output <= 1'b0;
        end else begin
            no_error_output            <= next_outs[0];
            position_reached_output    <= next_outs[1];
            power_stage_off_output     <= next_outs[2];
            axis_energized_zero_output <= next_outs[3];
        end
    end

    // Status words sampled on every clock, so they lag inputs by one cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_status_word <= dcs_pkg::SW_RESET;
        end else begin // see (RULE18)
            primary_status_word[dcs_pkg::SW1_PINS_MSB:dcs_pkg::SW1_PINS_LSB]
                <= pins; // see (RULE10)
            primary_status_word[dcs_pkg::SW1_NO_ERROR]  <= drive.no_error; // see (RULE11)
            primary_status_word[dcs_pkg::SW1_POS_REACH] <= drive.position_reached;
            primary_status_word[dcs_pkg::SW1_POWERLESS] <= drive.power_stage_off;
            primary_status_word[dcs_pkg::SW1_ENER_ZERO] <= drive.axis_energized_zero;
            primary_status_word[dcs_pkg::SW1_HOME_KNOWN] <= drive.home_known; // see (RULE13)
            primary_status_word[dcs_pkg::SW1_PSB_MSB:dcs_pkg::SW1_PSB_LSB]
                <= psb_flags; // see (RULE14)
        end
    end

    // Only the registration bit is live; the rest is held at zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            secondary_status_word <= dcs_pkg::SW_RESET;
        end else begin
            secondary_status_word <= dcs_pkg::SW_RESET; // see (RULE18)
            secondary_status_word[dcs_pkg::SW2_REG_DET] <= drive.reg_detected; // see (RULE15)
        end
    end

endmodule

// >>> verilog/dcs_psb_unit.sv
`timescale 1ns/1ps
module dcs_psb_unit (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // Pattern table write
    input  wire logic                 tbl_wr,
    input  wire logic [4:0]           tbl_addr,
    input  wire dcs_pkg::dcs_psb_pat_t tbl_data,
    // Apply request at set termination
    input  wire logic                 apply,
    input  wire logic [4:0]           apply_addr,
    // Flag state
    output logic [2:0]                flags
);

    dcs_pkg::dcs_psb_pat_t table_mem [dcs_pkg::SET_COUNT];
    dcs_pkg::dcs_psb_pat_t pat;

    // One flag follows its action; keep leaves it alone
    function automatic logic act(input dcs_pkg::dcs_psb_act_t a, input logic cur);
        case (a)
            dcs_pkg::DCS_PSB_CLEAR: act = 1'b0;
            dcs_pkg::DCS_PSB_SET:   act = 1'b1;
            default:                act = cur;
        endcase
    endfunction

    // Table resets to keep, so an unprogrammed set never disturbs flags
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < dcs_pkg::SET_COUNT; i++) begin
                table_mem[i] <= '{default: dcs_pkg::DCS_PSB_KEEP};
            end
        end else if (tbl_wr) begin
            table_mem[tbl_addr] <= tbl_data;
        end
    end

    assign pat = table_mem[apply_addr];

    // Pattern of the finished set is applied once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= dcs_pkg::PSB_RESET;
        end else if (apply) begin
            flags[0] <= act(pat.flag_zero, flags[0]); // see (RULE17)
            flags[1] <= act(pat.flag_one, flags[1]);
            flags[2] <= act(pat.flag_two, flags[2]);
        end
    end

endmodule
